//--- rtl/gpc_cfg_top.sv
`timescale 1ns/1ps
module gpc_cfg_top (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [3:0] iq_sample_in,
  output logic [3:0] stream_data_out,
  output logic stream_clk_out,
  output logic word_pulse_out,
  output logic frame_sync_out,
  output logic time_sync_out,
  output logic inphase_amp_on_out,
  output logic quadrature_amp_on_out,
  output logic stream_if_on_out,
  output logic [1:0] streamed_bit_count_out,
  output logic [2:0] clock_out_scale_out,
  output logic osc_band_select_out,
  output logic clock_out_buffer_on_out,
  output logic [1:0] crystal_current_out,
  output logic pump_current_select_out,
  output logic integer_n_mode_out,
  output logic loop_power_save_out,
  output logic [14:0] main_divide_ratio_out,
  output logic [9:0] reference_divide_ratio_out,
  output logic [19:0] fraction_divide_ratio_out,
  output logic external_sample_clock_select_out,
  output logic [11:0] ref_l_counter_out,
  output logic [11:0] ref_m_counter_out,
  output logic frac_divider_feeds_converter_out,
  output logic converter_clock_bypass_out
);
  typedef struct packed {
    gpc_pkg::gpc_bank_t regs;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    gpc_pkg::gpc_strm_st_t st;
    logic [1:0] bdiv;
    logic [3:0] bitc;
    logic [2:0] wordc;
    logic [15:0] fnum;
    logic sclk;
    logic wsync;
    logic fsync;
    logic tsync;
  } gpc_top_state_t;

  gpc_top_state_t s_reg;
  gpc_top_state_t s_next;

  // Word-aligned decode into a bank slot, or none
  function automatic logic [3:0] gpc_slot(input logic [7:0] a);
    logic [5:0] w;
    w = a[7:2] - gpc_pkg::IDX_STREAM;
    if (a[1:0] != 2'h0 || a[7:2] < gpc_pkg::IDX_STREAM ||
        a[7:2] > gpc_pkg::IDX_TEST1) begin
      gpc_slot = gpc_pkg::SLOT_NONE;
    end else begin
      gpc_slot = w[3:0];
    end
  endfunction : gpc_slot

  // Byte-lane merge under write strobes
  function automatic logic [31:0] gpc_merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : gpc_merge

  logic [3:0] hit;
  logic [2:0] sel;
  logic setup;
  logic wr_ok;
  logic [31:0] wword;
  logic ctl_wr;
  logic [31:0] ctl_word;
  logic go_edge;
  logic halt_edge;
  logic clr;
  logic if_on;
  logic tick;
  logic wrap_word;
  logic frame_start;
  logic run;
  logic [3:0] samp;
  logic [3:0] lane_en;

  assign hit = gpc_slot(paddr_in);
  assign sel = (hit == gpc_pkg::SLOT_NONE) ? 3'h0 : hit[2:0];
  assign setup = psel_in & ~penable_in;
  assign wr_ok = psel_in & penable_in & s_reg.pready & pwrite_in &
    (hit != gpc_pkg::SLOT_NONE);
  assign wword = gpc_merge(s_reg.regs[sel], pwdata_in, pstrb_in);
  assign ctl_wr = wr_ok & (hit == 4'h0);
  assign go_edge = ctl_wr & wword[gpc_pkg::POS_GO] &
    ~s_reg.regs[0][gpc_pkg::POS_GO];
  assign halt_edge = ctl_wr & wword[gpc_pkg::POS_HALT] &
    ~s_reg.regs[0][gpc_pkg::POS_HALT];
  assign clr = ctl_wr & wword[gpc_pkg::POS_CLR];
  // Control word as it stands after this cycle, without reading s_next
  assign ctl_word = ctl_wr ? wword : s_reg.regs[0];
  assign if_on = ctl_word[gpc_pkg::POS_IF_ON];
  assign tick = if_on & ~clr & (s_reg.bdiv == gpc_pkg::BIT_LAST);
  assign wrap_word = tick & (s_reg.bitc == gpc_pkg::WORD_LAST);
  assign frame_start = wrap_word & (s_reg.wordc == gpc_pkg::FRAME_LAST);
  assign run = (s_reg.st == gpc_pkg::GPC_RUN) ? (if_on & ~halt_edge) :
    (go_edge & ~halt_edge & if_on);

  always_comb begin
    s_next = s_reg;
    // Reads are captured in setup so access is zero-wait
    s_next.pready = setup;
    s_next.pslverr = setup & (hit == gpc_pkg::SLOT_NONE);
    s_next.prdata = '0;
    if (setup && !pwrite_in && hit != gpc_pkg::SLOT_NONE) begin
      s_next.prdata = s_reg.regs[sel];
    end
    if (wr_ok) begin
      s_next.regs[sel] = wword;
    end
    unique case (s_reg.st)
      gpc_pkg::GPC_IDLE: begin
        if (go_edge && !halt_edge && if_on) begin
          s_next.st = gpc_pkg::GPC_RUN;
        end
      end
      gpc_pkg::GPC_RUN: begin
        if (halt_edge || !if_on) begin
          s_next.st = gpc_pkg::GPC_IDLE;
        end
      end
    endcase
    if (!if_on || clr) begin
      s_next.bdiv = '0;
      s_next.bitc = '0;
      s_next.wordc = '0;
      s_next.fnum = '0;
    end else begin
      s_next.bdiv = tick ? 2'h0 : s_reg.bdiv + 2'h1;
      if (tick) begin
        s_next.bitc = s_reg.bitc + 4'h1;
      end
      if (wrap_word) begin
        s_next.wordc = s_reg.wordc + 3'h1;
      end
      if (frame_start) begin
        s_next.fnum = s_reg.fnum + 16'h1;
      end
    end
    s_next.sclk = run & (s_next.bdiv < gpc_pkg::BIT_HALF);
    s_next.wsync = run & wrap_word &
      s_next.regs[0][gpc_pkg::POS_WPO];
    s_next.fsync = run & frame_start;
    s_next.tsync = if_on & frame_start &
      (run | s_next.regs[0][gpc_pkg::POS_TPA]);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
      s_reg.regs <= gpc_pkg::BANK_RST;
      s_reg.st <= gpc_pkg::GPC_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  gpc_sync #(
    .W(4)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .async_in(iq_sample_in),
    .sync_out(samp)
  );

  // Lanes 0,1 carry I bits, lanes 2,3 Q bits
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_lane
      if (k < 2) begin : g_i
        assign lane_en[k] = run & (s_next.regs[0][gpc_pkg::POS_BITCNT +: 2]
          == gpc_pkg::CODE_I || s_next.regs[0][gpc_pkg::POS_BITCNT +: 2]
          == gpc_pkg::CODE_IQ);
      end else begin : g_q
        assign lane_en[k] = run & (s_next.regs[0][gpc_pkg::POS_BITCNT +: 2]
          == gpc_pkg::CODE_IQ);
      end
      gpc_lane u_lane (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .sample_in(samp[3-k]),
        .clear_in(~if_on | clr),
        .tick_in(tick),
        .load_in(wrap_word),
        .stamp_in(frame_start & s_next.regs[0][gpc_pkg::POS_STAMP]),
        .stamp_word_in(s_next.fnum),
        .en_in(lane_en[k]),
        .bit_out(stream_data_out[k])
      );
    end
  endgenerate

  assign prdata_out = s_reg.prdata;
  assign pready_out = s_reg.pready;
  assign pslverr_out = s_reg.pslverr;
  assign stream_clk_out = s_reg.sclk;
  assign word_pulse_out = s_reg.wsync;
  assign frame_sync_out = s_reg.fsync;
  assign time_sync_out = s_reg.tsync;
  assign inphase_amp_on_out = s_reg.regs[0][gpc_pkg::POS_I_AMP];
  assign quadrature_amp_on_out = s_reg.regs[0][gpc_pkg::POS_Q_AMP];
  assign stream_if_on_out = s_reg.regs[0][gpc_pkg::POS_IF_ON];
  assign streamed_bit_count_out =
    s_reg.regs[0][gpc_pkg::POS_BITCNT +: 2];
  assign clock_out_scale_out = s_reg.regs[1][gpc_pkg::POS_SCALE +: 3];
  assign osc_band_select_out = s_reg.regs[1][gpc_pkg::POS_BAND];
  assign clock_out_buffer_on_out = s_reg.regs[1][gpc_pkg::POS_BUF];
  assign crystal_current_out = s_reg.regs[1][gpc_pkg::POS_XTAL +: 2];
  assign pump_current_select_out = s_reg.regs[1][gpc_pkg::POS_PUMP];
  assign integer_n_mode_out = s_reg.regs[1][gpc_pkg::POS_INTN];
  assign loop_power_save_out = s_reg.regs[1][gpc_pkg::POS_PSAVE];
  assign main_divide_ratio_out =
    s_reg.regs[2][gpc_pkg::POS_MAIN_DIVIDE_RATIO +: 15];
  assign reference_divide_ratio_out =
    s_reg.regs[2][gpc_pkg::POS_REFERENCE_DIVIDE_RATIO +: 10];
  assign fraction_divide_ratio_out =
    s_reg.regs[3][gpc_pkg::POS_FRACTION_DIVIDE_RATIO +: 20];
  assign external_sample_clock_select_out =
    s_reg.regs[5][gpc_pkg::POS_EXTCLK];
  assign ref_l_counter_out = s_reg.regs[5][gpc_pkg::POS_LCNT +: 12];
  assign ref_m_counter_out = s_reg.regs[5][gpc_pkg::POS_MCNT +: 12];
  assign frac_divider_feeds_converter_out =
    s_reg.regs[5][gpc_pkg::POS_FRAC];
  assign converter_clock_bypass_out = s_reg.regs[5][gpc_pkg::POS_BYP];

  a_amp_follow_write:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ctl_wr && pstrb_in[1]) |=>
      (inphase_amp_on_out == $past(pwdata_in[13]) &&
       quadrature_amp_on_out == $past(pwdata_in[12])))
    else $error("amplifier enable did not follow write");

  a_path_absent_off:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !stream_if_on_out |-> (stream_data_out == 4'h0 && !stream_clk_out &&
      !word_pulse_out && !frame_sync_out && !time_sync_out))
    else $error("stream outputs active while interface off");

  a_start_brings_clock:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (go_edge && !halt_edge && if_on && s_reg.st == gpc_pkg::GPC_IDLE)
      ##1 (stream_if_on_out && !ctl_wr) [*4] |->
      (stream_clk_out || $past(stream_clk_out, 1) ||
       $past(stream_clk_out, 2) || $past(stream_clk_out, 3)))
    else $error("stream clock did not start");

  a_stop_goes_quiet:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    halt_edge |=> (!stream_clk_out && stream_data_out == 4'h0 &&
      !frame_sync_out && !word_pulse_out) [*2])
    else $error("stream still active after stop");

  a_lane_select_q:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (streamed_bit_count_out != gpc_pkg::CODE_IQ) |->
      stream_data_out[3:2] == 2'h0)
    else $error("quadrature lanes driven without I and Q code");

  a_time_pulse_gate:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    time_sync_out |-> (stream_if_on_out &&
      (s_reg.st == gpc_pkg::GPC_RUN || s_reg.regs[0][2])))
    else $error("time pulse outside allowed interval");

  a_word_pulse_gap:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    word_pulse_out |-> s_reg.regs[0][1] ##1 !word_pulse_out [*8])
    else $error("word pulse disabled or too close");

  a_clear_counters:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clr |=> (s_reg.fnum == 16'h0 && s_reg.bitc == 4'h0 &&
      s_reg.bdiv == 2'h0 && s_reg.wordc == 3'h0))
    else $error("stream counters not cleared");

  a_ratio_reset:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !$past(resetn_in) |-> (main_divide_ratio_out == gpc_pkg::MAIN_DIVIDE_RATIO_RST &&
      reference_divide_ratio_out == gpc_pkg::REFERENCE_DIVIDE_RATIO_RST))
    else $error("integer divide reset value wrong");

  a_frac_reset:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !$past(resetn_in) |-> fraction_divide_ratio_out == 20'h80000)
    else $error("fraction divide reset value wrong");

  a_counter_reset:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !$past(resetn_in) |-> (ref_l_counter_out == gpc_pkg::LCNT_RST &&
      ref_m_counter_out == gpc_pkg::MCNT_RST))
    else $error("L or M counter reset value wrong");

  a_scale_follow_write:
  assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (wr_ok && hit == 4'h1 && pstrb_in[3]) |=>
      clock_out_scale_out == $past(pwdata_in[31:29]))
    else $error("clock output scale did not follow write");
endmodule : gpc_cfg_top

//--- rtl/gpc_lane.sv
`timescale 1ns/1ps
module gpc_lane (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sample_in,
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic stamp_in,
  input wire logic [15:0] stamp_word_in,
  input wire logic en_in,
  output logic bit_out
);
  typedef struct packed {
    logic [15:0] cap;
    logic [15:0] sh;
    logic dat;
  } gpc_lane_state_t;
  gpc_lane_state_t s_reg;
  gpc_lane_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (clear_in) begin
      s_next.cap = '0;
      s_next.sh = '0;
    end else if (tick_in) begin
      s_next.cap = {s_reg.cap[14:0], sample_in};
      if (load_in && stamp_in) begin
        s_next.sh = stamp_word_in;
      end else if (load_in) begin
        s_next.sh = {s_reg.cap[14:0], sample_in};
      end else begin
        s_next.sh = {s_reg.sh[14:0], 1'b0};
      end
    end
    s_next.dat = en_in & s_next.sh[15];
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bit_out = s_reg.dat;
endmodule : gpc_lane

//--- rtl/gpc_sync.sv
`timescale 1ns/1ps
module gpc_sync #(
  parameter int W = 4
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } gpc_sync_state_t;
  gpc_sync_state_t s_reg;
  gpc_sync_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.meta = async_in;
    s_next.held = s_reg.meta;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.held;
endmodule : gpc_sync

//--- shared/gpc_pkg.sv
package gpc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_STREAM = 6'h02;
  localparam logic [5:0] IDX_SYNTH = 6'h03;
  localparam logic [5:0] IDX_INTDIV = 6'h04;
  localparam logic [5:0] IDX_FRACDIV = 6'h05;
  localparam logic [5:0] IDX_RSVD6 = 6'h06;
  localparam logic [5:0] IDX_CLK1 = 6'h07;
  localparam logic [5:0] IDX_TEST1 = 6'h08;
  localparam logic [3:0] SLOT_NONE = 4'hF;

  localparam logic [31:0] RST_STREAM = 32'h0EAFA1DC;
  localparam logic [31:0] RST_SYNTH = 32'h698C0000;
  localparam logic [31:0] RST_INTDIV = 32'h00C00080;
  localparam logic [31:0] RST_FRACDIV = 32'h08000070;
  localparam logic [31:0] RST_RSVD6 = 32'h08000000;
  localparam logic [31:0] RST_CLK1 = 32'h010061B2;
  localparam logic [31:0] RST_TEST1 = 32'h0100F401;

  typedef logic [6:0][31:0] gpc_bank_t;
  localparam gpc_bank_t BANK_RST = {RST_TEST1, RST_CLK1, RST_RSVD6,
    RST_FRACDIV, RST_INTDIV, RST_SYNTH, RST_STREAM};

  // Field positions, stream control word
  localparam int POS_I_AMP = 13;
  localparam int POS_Q_AMP = 12;
  localparam int POS_IF_ON = 11;
  localparam int POS_GO = 10;
  localparam int POS_HALT = 9;
  localparam int POS_BITCNT = 4;
  localparam int POS_STAMP = 3;
  localparam int POS_TPA = 2;
  localparam int POS_WPO = 1;
  localparam int POS_CLR = 0;
  // Synthesizer word
  localparam int POS_SCALE = 29;
  localparam int POS_BAND = 28;
  localparam int POS_BUF = 24;
  localparam int POS_XTAL = 19;
  localparam int POS_PUMP = 9;
  localparam int POS_INTN = 3;
  localparam int POS_PSAVE = 2;
  // Divide words
  localparam int POS_MAIN_DIVIDE_RATIO = 13;
  localparam int POS_REFERENCE_DIVIDE_RATIO = 3;
  localparam int POS_FRACTION_DIVIDE_RATIO = 8;
  // Converter clock word
  localparam int POS_EXTCLK = 28;
  localparam int POS_LCNT = 16;
  localparam int POS_MCNT = 4;
  localparam int POS_FRAC = 3;
  localparam int POS_BYP = 2;

  localparam logic [1:0] CODE_I = 2'h1;
  localparam logic [1:0] CODE_IQ = 2'h3;
  localparam logic [14:0] MAIN_DIVIDE_RATIO_RST = 15'h0600;
  localparam logic [9:0] REFERENCE_DIVIDE_RATIO_RST = 10'h010;
  localparam logic [19:0] FRACTION_DIVIDE_RATIO_RST = 20'h80000;
  localparam logic [11:0] LCNT_RST = 12'h100;
  localparam logic [11:0] MCNT_RST = 12'h61B;

  // Stream timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_PERIOD_NS = 32;
  localparam int BIT_DIV = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] BIT_LAST = 2'(BIT_DIV - 1);
  localparam logic [1:0] BIT_HALF = 2'(BIT_DIV / 2);
  localparam logic [3:0] WORD_LAST = 4'hF;
  localparam logic [2:0] FRAME_LAST = 3'h7;

  typedef enum logic {GPC_IDLE, GPC_RUN} gpc_strm_st_t;
endpackage : gpc_pkg

//--- verification/gpc_cfg_top_tb.sv
`timescale 1ns/1ps
module gpc_cfg_top_tb;
  logic ref_clk_in, resetn_in, psel, pen, pwr, prdy, perr, er;
  logic [7:0] paddr;
  logic [3:0] pstrb, iq_sample_in, sdata;
  logic [31:0] pwdata, prdata, rd, rng;
  logic sclk, wpl, fsy, tsy, ia, qa, ifo, band, buf_on, pump, intn, psave;
  logic extc, fracc, byp;
  logic [1:0] bitc, xtal;
  logic [2:0] scale;
  logic [14:0] main_divide_ratio;
  logic [9:0] reference_divide_ratio;
  logic [19:0] fraction_divide_ratio;
  logic [11:0] lcnt, mcnt;
  logic [31:0] model [2:8];
  logic [31:0] msk [2:8] = '{32'h00003000, 32'hF118020C, 32'h0FFFFFF8,
    32'h0FFFFF00, 32'h00000000, 32'h1FFFFFFC, 32'h00000000};
  int sel [5] = '{2, 3, 4, 5, 7};
  int fail_count, checks_done, nw, nf, nt, nc, wf, d1;
  int nl [4];

  gpc_host host (.ref_clk_in(ref_clk_in), .psel_out(psel),
    .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr),
    .pwdata_out(pwdata), .pstrb_out(pstrb), .prdata_in(prdata),
    .pready_in(prdy), .pslverr_in(perr));

  gpc_cfg_top uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(prdy), .pslverr_out(perr), .iq_sample_in(iq_sample_in),
    .stream_data_out(sdata), .stream_clk_out(sclk),
    .word_pulse_out(wpl), .frame_sync_out(fsy), .time_sync_out(tsy),
    .inphase_amp_on_out(ia), .quadrature_amp_on_out(qa),
    .stream_if_on_out(ifo), .streamed_bit_count_out(bitc),
    .clock_out_scale_out(scale), .osc_band_select_out(band),
    .clock_out_buffer_on_out(buf_on), .crystal_current_out(xtal),
    .pump_current_select_out(pump), .integer_n_mode_out(intn),
    .loop_power_save_out(psave), .main_divide_ratio_out(main_divide_ratio),
    .reference_divide_ratio_out(reference_divide_ratio), .fraction_divide_ratio_out(fraction_divide_ratio),
    .external_sample_clock_select_out(extc), .ref_l_counter_out(lcnt),
    .ref_m_counter_out(mcnt), .frac_divider_feeds_converter_out(fracc),
    .converter_clock_bypass_out(byp));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic cfg_chk;
    chk(ia, model[2][13]);
    chk(qa, model[2][12]);
    chk(ifo, model[2][11]);
    chk(bitc, model[2][5:4]);
    chk(scale, model[3][31:29]);
    chk(band, model[3][28]);
    chk(buf_on, model[3][24]);
    chk(xtal, model[3][20:19]);
    chk(pump, model[3][9]);
    chk(intn, model[3][3]);
    chk(psave, model[3][2]);
    chk(main_divide_ratio, model[4][27:13]);
    chk(reference_divide_ratio, model[4][12:3]);
    chk(fraction_divide_ratio, model[5][27:8]);
    chk(extc, model[7][28]);
    chk(lcnt, model[7][27:16]);
    chk(mcnt, model[7][15:4]);
    chk(fracc, model[7][3]);
    chk(byp, model[7][2]);
  endtask : cfg_chk

  task automatic rd_chk(input int i);
    host.xfer(1'b0, 8'(i * 4), 32'h00000000, rd, er);
    chk(rd, model[i]);
    chk(er, 1'b0);
  endtask : rd_chk

  task automatic wr(input int i, input logic [31:0] m, input logic [31:0] d);
    host.update(8'(i * 4), m, d);
    model[i] = (model[i] & ~m) | (d & m);
    @(negedge ref_clk_in);
    cfg_chk();
  endtask : wr

  task automatic s(input logic [31:0] d);
    wr(2, 32'h00003E3F, d);
  endtask : s

  task automatic watch(input int n);
    nw = 0;
    nf = 0;
    nt = 0;
    nc = 0;
    nl = '{0, 0, 0, 0};
    repeat (n) begin
      @(negedge ref_clk_in);
      nw += wpl;
      nf += fsy;
      nt += tsy;
      nc += sclk;
      for (int k = 0; k < 4; k++) nl[k] += sdata[k];
    end
  endtask : watch

  task automatic wait_frame;
    wf = 0;
    do begin
      @(negedge ref_clk_in);
      wf++;
    end while (fsy !== 1'b1 && wf < 2000);
    chk(fsy, 1'b1);
  endtask : wait_frame

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    #150000;
    fail_count++;
    stop_test();
  end

  initial begin
    fail_count = 0;
    checks_done = 0;
    rng = 32'h6e0aea10;
    resetn_in = 1'b0;
    iq_sample_in = 4'h0;
    for (int i = 2; i <= 8; i++) model[i] = gpc_pkg::BANK_RST[i - 2];
    repeat (10) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    iq_sample_in <= 4'hF;
    @(negedge ref_clk_in);
    chk(main_divide_ratio, 15'h0600);
    chk(reference_divide_ratio, 10'h010);
    chk(fraction_divide_ratio, 20'h80000);
    chk(lcnt, 12'h100);
    chk(mcnt, 12'h61B);
    chk({sclk, wpl, fsy, tsy, sdata}, 8'h00);
    cfg_chk();
    for (int i = 2; i <= 8; i++) rd_chk(i);
    for (int j = 0; j < 16; j++) begin
      rng = xs(rng);
      d1 = sel[rng % 5];
      rng = xs(rng);
      wr(d1, msk[d1], rng);
      rd_chk(d1);
    end
    foreach (sel[j]) begin
      rng = xs(rng);
      host.xfer(1'b1, 8'(8'h21 + j * 32), rng, rd, er);
      chk(er, 1'b1);
      host.xfer(1'b0, 8'(8'h21 + j * 32), 32'h00000000, rd, er);
      chk({er, rd}, 33'h100000000);
    end
    for (int i = 2; i <= 8; i++) rd_chk(i);
    s(32'h00003832);
    watch(600);
    chk({nc, nw, nt}, 96'h0);
    s(32'h00003C32);
    watch(100);
    watch(512);
    chk(nc, 256);
    chk(nw, 8);
    chk(nf, 1);
    chk(nt, 1);
    chk(nl[0] > 0 && nl[3] > 0, 1'b1);
    s(32'h00003C12);
    watch(64);
    watch(512);
    chk(nl[2] + nl[3], 0);
    chk(nl[1] > 0, 1'b1);
    s(32'h00003C10);
    watch(512);
    chk(nw, 0);
    s(32'h00003C18);
    wait_frame();
    wait_frame();
    watch(64);
    chk(nl[0] != 64, 1'b1);
    s(32'h00003C10);
    wait_frame();
    wait_frame();
    watch(64);
    chk(nl[0], 64);
    s(32'h00003C11);
    wait_frame();
    d1 = wf;
    rng = xs(rng);
    repeat (rng % 64) @(negedge ref_clk_in);
    s(32'h00003C11);
    wait_frame();
    chk(wf, d1);
    chk(d1, gpc_pkg::BIT_DIV * 16 * 8);
    s(32'h00003E10);
    watch(520);
    chk({nc, nf, nt}, 96'h0);
    s(32'h00003E14);
    watch(512);
    chk(nt, 1);
    chk(nc, 0);
    s(32'h00003614);
    watch(520);
    chk({nt, nc}, 64'h0);
    stop_test();
  end
endmodule : gpc_cfg_top_tb

//--- verification/gpc_host.sv
`timescale 1ns/1ps
module gpc_host (
  input wire logic ref_clk_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic [3:0] pstrb_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h00000000;
    pstrb_out = 4'hF;
  end

  // No latency assumed: waits for pready, bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge ref_clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge ref_clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask : xfer

  // Field update that writes back every other bit as read
  task automatic update(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h00000000, r, e);
    xfer(1'b1, a, (r & ~m) | (d & m), r, e);
  endtask : update
endmodule : gpc_host
